// ### bench/pals_mem_model.sv
module pals_mem_model (
   input wire logic clk,
   input wire logic rstn,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [15:0] mem_addr,
   input wire logic [15:0] mem_wdata,
   output logic mem_rvalid,
   output logic [15:0] mem_rdata,
   input wire logic table_req,
   input wire logic [15:0] table_label,
   input wire logic [15:0] table_index,
   output logic table_rvalid,
   output logic [15:0] table_rdata,
   input wire logic bit_we,
   input wire logic [15:0] bit_addr,
   input wire logic bit_wdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] mem [0:1023];
   logic bits [0:1023];
   int lat;
   int rcnt;
   logic rpend;
   logic [9:0] radr;

   initial begin
      lat = 0;
      mem_rdata = 16'h5a5a;
      table_rdata = 16'ha5a5;
   end

   // ==========================================
   // word memory
   // read data toggles while not valid, so a stale sample never matches
   // real in two words
   always @(posedge clk) begin
      mem_rvalid <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (!rstn) begin
         rpend <= 1'b0;
      end else if (mem_req && mem_we) begin
         mem[mem_addr[9:0]] <= mem_wdata;
      end else if (mem_req) begin
         rpend <= 1'b1;
         radr <= mem_addr[9:0];
         rcnt <= lat;
      end else if (rpend && rcnt > 0) begin
         rcnt <= rcnt - 1;
      end else if (rpend) begin
         rpend <= 1'b0;
         mem_rvalid <= 1'b1;
         mem_rdata <= mem[radr];
      end
   end

   // ==========================================
   // constant table and discrete bits
   // entry is a mix of label and offset so a wrong offset shows
   always @(posedge clk) begin
      table_rvalid <= rstn && table_req;
      if (table_req) begin
         table_rdata <= table_label ^ {table_index[7:0], table_index[15:8]};
      end else begin
         table_rdata <= ~table_rdata;
      end
   end

   always @(posedge clk) begin
      if (bit_we) begin
         bits[bit_addr[9:0]] <= bit_wdata;
      end
   end
endmodule

// ### bench/plc_accumulator_load_store_tb.sv
module plc_accumulator_load_store_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rstn, cmd_valid, cmd_pointer, logic_unsolvable, fault_clear;
   pals_pkg::pals_op_t cmd_op;
   logic [15:0] cmd_addr, mem_addr, mem_wdata, mem_rdata, table_label, table_index;
   logic [15:0] table_rdata, bit_addr;
   logic [31:0] cmd_operand, acc_value, stack_top;
   logic [5:0] cmd_bit_count;
   logic cmd_ready, cmd_done, mem_req, mem_we, mem_rvalid, table_req, table_rvalid;
   logic bit_we, bit_wdata, zero_result_flag, logic_fault_flag;
   int err_count = 0;
   int compares = 0;

   pals_core uut (.clk, .rstn, .cmd_valid, .cmd_op, .cmd_addr, .cmd_operand, .cmd_bit_count,
      .cmd_pointer, .logic_unsolvable, .fault_clear, .cmd_ready, .cmd_done, .mem_req, .mem_we,
      .mem_addr, .mem_wdata, .mem_rvalid, .mem_rdata, .table_req, .table_label, .table_index,
      .table_rvalid, .table_rdata, .bit_we, .bit_addr, .bit_wdata, .acc_value, .stack_top,
      .zero_result_flag, .logic_fault_flag);

   pals_mem_model mdl (.clk, .rstn, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rvalid,
      .mem_rdata, .table_req, .table_label, .table_index, .table_rvalid, .table_rdata,
      .bit_we, .bit_addr, .bit_wdata);

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ==========================================
   // reporting
   task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk1(input string what, input logic exp, input logic got);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic stop_test;
      if (err_count == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ==========================================
   // one instruction, start to done; always entered 1 ns after an edge
   task automatic issue(input pals_pkg::pals_op_t op, input logic [15:0] a,
         input logic [31:0] d, input logic [5:0] n = 6'h01, input logic p = 1'b0);
      int i;
      i = 0;
      while (cmd_ready !== 1'b1 && i < 50) begin
         @(posedge clk);
         #1;
         i++;
      end
      cmd_op = op;
      cmd_addr = a;
      cmd_operand = d;
      cmd_bit_count = n;
      cmd_pointer = p;
      cmd_valid = 1'b1;
      @(posedge clk);
      #1;
      cmd_valid = 1'b0;
      i = 0;
      while (cmd_done !== 1'b1 && i < 200) begin
         @(posedge clk);
         #1;
         i++;
      end
      if (cmd_done !== 1'b1) begin
         err_count++;
         $display("CHECK FAILED cmd_done expected 1 seen %b", cmd_done);
         stop_test();
      end
   endtask

   // ==========================================
   // scenarios
   task automatic t_real_const;
      issue(pals_pkg::OP_OTHER, 16'h0000, 32'h0);
      issue(pals_pkg::OP_LOAD_REAL_CONST, 16'h0000, 32'hc049_0fdb);
      chk32("acc", 32'hc049_0fdb, acc_value);
      chk1("zero", 1'b0, zero_result_flag);
      issue(pals_pkg::OP_STORE_DOUBLE_WORD, 16'h0100, 32'h0);
      chk32("dw_lo", 32'h0000_0fdb, {16'h0000, mdl.mem[16'h100]});
      chk32("dw_hi", 32'h0000_c049, {16'h0000, mdl.mem[16'h101]});
   endtask

   task automatic t_push;
      issue(pals_pkg::OP_LOAD_REAL_CONST, 16'h0000, 32'h1111_2222);
      issue(pals_pkg::OP_LOAD_REAL_CONST, 16'h0000, 32'h3333_4444);
      chk32("stack", 32'h1111_2222, stack_top);
      issue(pals_pkg::OP_LOAD_REAL_CONST, 16'h0000, 32'h5555_6666);
      chk32("stack", 32'h3333_4444, stack_top);
      chk32("stack1", 32'h1111_2222, uut.stack[1]);
   endtask

   task automatic t_indexed;
      issue(pals_pkg::OP_OTHER, 16'h0000, 32'h0);
      issue(pals_pkg::OP_LOAD_REAL_CONST, 16'h0000, 32'habcd_0010);
      issue(pals_pkg::OP_LOAD_INDEXED_CONSTANT, 16'h0000, 32'h0000_0002);
      chk32("stack", 32'habcd_0010, stack_top);
      chk32("acc", 32'h0000_1002, acc_value);
      issue(pals_pkg::OP_LOAD_INDEXED_CONSTANT, 16'h0000, 32'h0000_ffff);
      chk32("stack", 32'h0000_1002, stack_top);
      chk32("acc", 32'h0000_fdef, acc_value);
   endtask

   task automatic t_real_mem;
      mdl.mem[16'h200] = 16'h0fdb;
      mdl.mem[16'h201] = 16'h4049;
      mdl.mem[16'h210] = 16'h2345;
      mdl.mem[16'h211] = 16'h6789;
      mdl.mem[16'h300] = 16'h0210;
      mdl.lat = 0;
      issue(pals_pkg::OP_OTHER, 16'h0000, 32'h0);
      issue(pals_pkg::OP_LOAD_REAL_MEM, 16'h0200, 32'h0);
      chk32("acc", 32'h4049_0fdb, acc_value);
      mdl.lat = 4;
      issue(pals_pkg::OP_LOAD_REAL_MEM, 16'h0300, 32'h0, 6'h01, 1'b1);
      chk32("acc", 32'h6789_2345, acc_value);
      chk32("stack", 32'h4049_0fdb, stack_top);
      mdl.lat = 0;
   endtask

   task automatic t_zero;
      issue(pals_pkg::OP_LOAD_REAL_CONST, 16'h0000, 32'h0);
      chk1("zero", 1'b1, zero_result_flag);
      issue(pals_pkg::OP_LOAD_REAL_CONST, 16'h0000, 32'h0001_0000);
      chk1("zero", 1'b0, zero_result_flag);
   endtask

   task automatic t_store_word;
      issue(pals_pkg::OP_LOAD_REAL_CONST, 16'h0000, 32'h1234_5678);
      mdl.mem[16'h041] = 16'haaaa;
      mdl.mem[16'h050] = 16'h0060;
      issue(pals_pkg::OP_STORE_WORD, 16'h0040, 32'h0);
      chk32("word", 32'h0000_5678, {16'h0000, mdl.mem[16'h040]});
      chk32("next", 32'h0000_aaaa, {16'h0000, mdl.mem[16'h041]});
      issue(pals_pkg::OP_STORE_WORD, 16'h0050, 32'h0, 6'h01, 1'b1);
      chk32("word", 32'h0000_5678, {16'h0000, mdl.mem[16'h060]});
      chk32("ptr", 32'h0000_0060, {16'h0000, mdl.mem[16'h050]});
   endtask

   task automatic t_fault;
      pals_pkg::pals_op_t ops [2];
      ops = '{pals_pkg::OP_STORE_WORD, pals_pkg::OP_STORE_DOUBLE_WORD};
      foreach (ops[j]) begin
         logic_unsolvable = 1'b1;
         issue(ops[j], 16'h0070, 32'h0);
         logic_unsolvable = 1'b0;
         @(posedge clk);
         #1;
         chk1("fault", 1'b1, logic_fault_flag);
         fault_clear = 1'b1;
         @(posedge clk);
         #1;
         fault_clear = 1'b0;
         @(posedge clk);
         #1;
         chk1("fault", 1'b0, logic_fault_flag);
      end
      @(posedge clk);
      #1;
      // clear held through a whole store: the set must still win
      fault_clear = 1'b1;
      logic_unsolvable = 1'b1;
      issue(pals_pkg::OP_STORE_WORD, 16'h0070, 32'h0);
      logic_unsolvable = 1'b0;
      chk1("fault_vs_clear", 1'b1, logic_fault_flag);
      @(posedge clk);
      #1;
      fault_clear = 1'b0;
      chk1("fault", 1'b0, logic_fault_flag);
   endtask

   task automatic t_bits;
      logic [31:0] v;
      logic [15:0] base;
      int ns [5];
      int m;
      v = 32'ha5c3_0f96;
      // 0 and 63 lie outside 1..32 and are held to the nearest end
      ns = '{1, 7, 32, 0, 63};
      issue(pals_pkg::OP_LOAD_REAL_CONST, 16'h0000, v);
      foreach (ns[j]) begin
         m = (ns[j] < 1) ? 1 : (ns[j] > 32) ? 32 : ns[j];
         base = 16'h0100 + 16'(64 * j);
         for (int k = 0; k < 34; k++) begin
            mdl.bits[base + k] = ~v[k % 32];
         end
         issue(pals_pkg::OP_STORE_BIT_FIELD, base, 32'h0, 6'(ns[j]));
         for (int k = 0; k <= m; k++) begin
            chk1("bit", (k < m) ? v[k % 32] : ~v[k % 32], mdl.bits[base + k]);
         end
      end
   endtask

   // ==========================================
   // main sequence
   initial begin
      rstn = 1'b0;
      cmd_valid = 1'b0;
      cmd_op = pals_pkg::OP_OTHER;
      cmd_addr = 16'h0000;
      cmd_operand = 32'h0;
      cmd_bit_count = 6'h01;
      cmd_pointer = 1'b0;
      logic_unsolvable = 1'b0;
      fault_clear = 1'b0;
      repeat (20) @(posedge clk);
      #1;
      rstn = 1'b1;
      chk32("acc", 32'h0, acc_value);
      chk32("stack", 32'h0, stack_top);
      chk1("ready", 1'b1, cmd_ready);
      t_real_const();
      t_push();
      t_indexed();
      t_real_mem();
      t_zero();
      t_store_word();
      t_fault();
      t_bits();
      stop_test();
   end
endmodule

// ### hw/pals_bit_field_writer.sv
module pals_bit_field_writer (
   input wire logic clk,
   input wire logic rstn,
   pals_bit_if.writer bif,
   output logic bit_we,
   output logic [pals_pkg::WORD_W-1:0] bit_addr,
   output logic bit_wdata
);
   logic busy;
   logic [pals_pkg::CNT_W-1:0] left;
   logic [pals_pkg::ACC_W-1:0] shreg;
   logic [pals_pkg::CNT_W-1:0] clamped;

   // out-of-range counts are forced into 1..32 rather than rejected
   always_comb begin
      clamped = bif.count;
      if (bif.count < pals_pkg::BITS_MIN) begin
         clamped = pals_pkg::BITS_MIN;
      end else if (bif.count > pals_pkg::BITS_MAX) begin
         clamped = pals_pkg::BITS_MAX;
      end
   end

   // ==========================================
   // serial bit walk
   // RL10 RL11 ascending bit walk
   always_ff @(posedge clk) begin
      if (!rstn) begin
         busy <= 1'b0;
         left <= '0;
         shreg <= pals_pkg::ACC_RESET;
         bit_we <= 1'b0;
         bit_addr <= pals_pkg::WORD_ZERO;
         bit_wdata <= 1'b0;
         bif.done <= 1'b0;
      end else begin
         bif.done <= 1'b0;
         bit_we <= 1'b0;
         if (!busy && bif.start) begin
            busy <= 1'b1;
            left <= clamped;
            shreg <= bif.data;
            bit_addr <= bif.base;
         end else if (busy) begin
            if (left == '0) begin
               busy <= 1'b0;
               bif.done <= 1'b1;
            end else begin
               bit_we <= 1'b1;
               bit_wdata <= shreg[0];
               shreg <= shreg >> 1;
               left <= pals_pkg::CNT_W'(left - 1'b1);
               if (bit_we) begin
                  bit_addr <= pals_pkg::next_addr(bit_addr);
               end
            end
         end
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   a_bit_addr_step: assert property ( // RL11
      bit_we && $past(bit_we) |-> bit_addr == pals_pkg::next_addr($past(bit_addr)))
      else $error("bit field address did not advance by one");
   a_bit_first_lsb: assert property ( // RL11
      !busy && bif.start ##1 busy |=> bit_we && bit_wdata == $past(bif.data[0], 2)
      && bit_addr == $past(bif.base, 2))
      else $error("first bit written is not bit 0 at start address");
   a_bit_single_done: assert property ( // RL10
      !busy && bif.start && bif.count == pals_pkg::BITS_MIN |=> ##1 bit_we ##1 bif.done)
      else $error("one-bit store did not finish after one write");
endmodule

// ### hw/pals_bit_if.sv
interface pals_bit_if;
   logic start;
   logic [pals_pkg::WORD_W-1:0] base;
   logic [pals_pkg::CNT_W-1:0] count;
   logic [pals_pkg::ACC_W-1:0] data;
   logic done;
   modport core (output start, base, count, data, input done);
   modport writer (input start, base, count, data, output done);
endinterface

// ### hw/pals_core.sv
module pals_core (
   input wire logic clk,
   input wire logic rstn,
   input wire logic cmd_valid,
   input wire pals_pkg::pals_op_t cmd_op,
   input wire logic [pals_pkg::WORD_W-1:0] cmd_addr,
   input wire logic [pals_pkg::ACC_W-1:0] cmd_operand,
   input wire logic [pals_pkg::CNT_W-1:0] cmd_bit_count,
   input wire logic cmd_pointer,
   input wire logic logic_unsolvable,
   input wire logic fault_clear,
   output logic cmd_ready,
   output logic cmd_done,
   output logic mem_req,
   output logic mem_we,
   output logic [pals_pkg::WORD_W-1:0] mem_addr,
   output logic [pals_pkg::WORD_W-1:0] mem_wdata,
   input wire logic mem_rvalid,
   input wire logic [pals_pkg::WORD_W-1:0] mem_rdata,
   output logic table_req,
   output logic [pals_pkg::WORD_W-1:0] table_label,
   output logic [pals_pkg::WORD_W-1:0] table_index,
   input wire logic table_rvalid,
   input wire logic [pals_pkg::WORD_W-1:0] table_rdata,
   output logic bit_we,
   output logic [pals_pkg::WORD_W-1:0] bit_addr,
   output logic bit_wdata,
   output logic [pals_pkg::ACC_W-1:0] acc_value,
   output logic [pals_pkg::ACC_W-1:0] stack_top,
   output logic zero_result_flag,
   output logic logic_fault_flag
);
   pals_pkg::pals_state_t state;
   pals_pkg::pals_op_t op;
   logic [pals_pkg::WORD_W-1:0] op_addr;
   logic [pals_pkg::WORD_W-1:0] eff_addr;
   logic [pals_pkg::ACC_W-1:0] operand;
   logic [pals_pkg::CNT_W-1:0] bit_count;
   logic use_ptr;
   logic prev_load;
   logic [pals_pkg::WORD_W-1:0] lo_word;
   logic [pals_pkg::ACC_W-1:0] stack [pals_pkg::STACK_DEPTH];
   logic accept;
   logic push;
   logic acc_wr;
   logic [pals_pkg::ACC_W-1:0] acc_val;
   logic fault_set;

   pals_bit_if bif ();

   assign accept = cmd_valid && cmd_ready;
   // RL4 push before reload
   assign push = accept && pals_pkg::is_load(cmd_op) && prev_load;
   // RL8 fault during word and double word stores, not bit field stores
   assign fault_set = logic_unsolvable && state != pals_pkg::S_IDLE &&
                      (op == pals_pkg::OP_STORE_WORD || op == pals_pkg::OP_STORE_DOUBLE_WORD);

   // ==========================================
   // accumulator write source
   always_comb begin
      acc_wr = 1'b0;
      acc_val = acc_value;
      case (state)
         pals_pkg::S_START: begin
            // RL5 RL14 constant copied bit exact
            if (op == pals_pkg::OP_LOAD_REAL_CONST) begin
               acc_wr = 1'b1;
               acc_val = operand;
            end
         end
         pals_pkg::S_TBL: begin
            // RL1 entry into low half
            if (table_rvalid) begin
               acc_wr = 1'b1;
               acc_val = {pals_pkg::WORD_ZERO, table_rdata};
            end
         end
         pals_pkg::S_RD_HI: begin
            // RL6 RL14 two adjacent words, no conversion
            if (mem_rvalid) begin
               acc_wr = 1'b1;
               acc_val = {mem_rdata, lo_word};
            end
         end
         default: begin
            acc_wr = 1'b0;
         end
      endcase
   end

   // ==========================================
   // command latch and handshake
   always_ff @(posedge clk) begin
      if (!rstn) begin
         op <= pals_pkg::OP_OTHER;
         op_addr <= pals_pkg::WORD_ZERO;
         operand <= pals_pkg::ACC_RESET;
         bit_count <= pals_pkg::BITS_MIN;
         use_ptr <= 1'b0;
         cmd_ready <= 1'b1;
         cmd_done <= 1'b0;
         prev_load <= 1'b0;
      end else begin
         cmd_done <= 1'b0;
         if (accept) begin
            op <= cmd_op;
            op_addr <= cmd_addr;
            operand <= cmd_operand;
            bit_count <= cmd_bit_count;
            use_ptr <= cmd_pointer;
            cmd_ready <= 1'b0;
         end else if (state == pals_pkg::S_FINISH) begin
            cmd_ready <= 1'b1;
            cmd_done <= 1'b1;
            // any other instruction breaks a run of loads
            prev_load <= pals_pkg::is_load(op);
         end
      end
   end

   // ==========================================
   // sequencer and memory ports
   always_ff @(posedge clk) begin
      if (!rstn) begin
         state <= pals_pkg::S_IDLE;
         eff_addr <= pals_pkg::WORD_ZERO;
         lo_word <= pals_pkg::WORD_ZERO;
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_addr <= pals_pkg::WORD_ZERO;
         mem_wdata <= pals_pkg::WORD_ZERO;
         table_req <= 1'b0;
         table_label <= pals_pkg::WORD_ZERO;
         table_index <= pals_pkg::WORD_ZERO;
         bif.start <= 1'b0;
         bif.base <= pals_pkg::WORD_ZERO;
         bif.count <= pals_pkg::BITS_MIN;
         bif.data <= pals_pkg::ACC_RESET;
      end else begin
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         table_req <= 1'b0;
         bif.start <= 1'b0;
         case (state)
            pals_pkg::S_IDLE: begin
               if (accept) begin
                  state <= pals_pkg::S_START;
               end
            end
            pals_pkg::S_START: begin
               eff_addr <= op_addr;
               case (op)
                  pals_pkg::OP_LOAD_INDEXED_CONSTANT: begin
                     // RL2 RL3 stack level one as binary offset
                     table_req <= 1'b1;
                     table_label <= operand[pals_pkg::WORD_W-1:0];
                     table_index <= stack[0][pals_pkg::WORD_W-1:0];
                     state <= pals_pkg::S_TBL;
                  end
                  pals_pkg::OP_LOAD_REAL_MEM,
                  pals_pkg::OP_STORE_WORD,
                  pals_pkg::OP_STORE_DOUBLE_WORD: begin
                     if (use_ptr) begin
                        mem_req <= 1'b1;
                        mem_addr <= op_addr;
                        state <= pals_pkg::S_PTR;
                     end else begin
                        state <= pals_pkg::S_ACCESS;
                     end
                  end
                  pals_pkg::OP_STORE_BIT_FIELD: begin
                     // RL10 hand bits to the walker
                     bif.start <= 1'b1;
                     bif.base <= op_addr;
                     bif.count <= bit_count;
                     bif.data <= acc_value;
                     state <= pals_pkg::S_BITS;
                  end
                  default: begin
                     state <= pals_pkg::S_FINISH;
                  end
               endcase
            end
            pals_pkg::S_PTR: begin
               if (mem_rvalid) begin
                  eff_addr <= mem_rdata;
                  state <= pals_pkg::S_ACCESS;
               end
            end
            pals_pkg::S_ACCESS: begin
               mem_req <= 1'b1;
               mem_addr <= eff_addr;
               if (op == pals_pkg::OP_LOAD_REAL_MEM) begin
                  state <= pals_pkg::S_RD_LO;
               end else if (op == pals_pkg::OP_STORE_WORD) begin
                  // RL7 low half to one word
                  mem_we <= 1'b1;
                  mem_wdata <= acc_value[pals_pkg::WORD_W-1:0];
                  state <= pals_pkg::S_FINISH;
               end else begin
                  // RL9 low word at start address
                  mem_we <= 1'b1;
                  mem_wdata <= acc_value[pals_pkg::WORD_W-1:0];
                  state <= pals_pkg::S_WR_HI;
               end
            end
            pals_pkg::S_RD_LO: begin
               // RL5 second word follows the first
               if (mem_rvalid) begin
                  lo_word <= mem_rdata;
                  mem_req <= 1'b1;
                  mem_addr <= pals_pkg::next_addr(eff_addr);
                  state <= pals_pkg::S_RD_HI;
               end
            end
            pals_pkg::S_RD_HI: begin
               if (mem_rvalid) begin
                  state <= pals_pkg::S_FINISH;
               end
            end
            pals_pkg::S_WR_HI: begin
               // RL9 high word at next address
               mem_req <= 1'b1;
               mem_we <= 1'b1;
               mem_addr <= pals_pkg::next_addr(eff_addr);
               mem_wdata <= acc_value[pals_pkg::ACC_W-1:pals_pkg::WORD_W];
               state <= pals_pkg::S_FINISH;
            end
            pals_pkg::S_TBL: begin
               if (table_rvalid) begin
                  state <= pals_pkg::S_FINISH;
               end
            end
            pals_pkg::S_BITS: begin
               if (bif.done) begin
                  state <= pals_pkg::S_FINISH;
               end
            end
            default: begin
               state <= pals_pkg::S_IDLE;
            end
         endcase
      end
   end

   // ==========================================
   // accumulator and zero flag
   always_ff @(posedge clk) begin
      if (!rstn) begin
         acc_value <= pals_pkg::ACC_RESET;
         zero_result_flag <= 1'b0;
      end else if (acc_wr) begin
         acc_value <= acc_val;
         // RL12 zero load result
         zero_result_flag <= (acc_val == pals_pkg::ACC_RESET);
      end
   end

   // ==========================================
   // accumulator stack
   // the deepest level falls off; nothing here pops it back
   always_ff @(posedge clk) begin
      if (!rstn) begin
         for (int i = 0; i < pals_pkg::STACK_DEPTH; i++) begin
            stack[i] <= pals_pkg::ACC_RESET;
         end
         stack_top <= pals_pkg::ACC_RESET;
      end else if (push) begin
         // RL13 shift deeper then store
         for (int i = 1; i < pals_pkg::STACK_DEPTH; i++) begin
            stack[i] <= stack[i-1];
         end
         stack[0] <= acc_value;
         stack_top <= acc_value;
      end
   end

   // ==========================================
   // logic fault flag, set beats clear
   always_ff @(posedge clk) begin
      if (!rstn) begin
         logic_fault_flag <= 1'b0;
      end else if (fault_set) begin
         logic_fault_flag <= 1'b1;
      end else if (fault_clear) begin
         logic_fault_flag <= 1'b0;
      end
   end

   pals_bit_field_writer u_bits (
      .clk(clk),
      .rstn(rstn),
      .bif(bif),
      .bit_we(bit_we),
      .bit_addr(bit_addr),
      .bit_wdata(bit_wdata)
   );

   // ==========================================
   // checks
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   a_reload_push_value: assert property ( // RL4
      push |=> stack[0] == $past(acc_value) && stack_top == $past(acc_value))
      else $error("back-to-back load did not push previous accumulator");
   a_stack_shift_deeper: assert property ( // RL13
      push |=> stack[1] == $past(stack[0]))
      else $error("stack did not shift one level deeper");
   a_index_from_stack: assert property ( // RL2
      state == pals_pkg::S_START && op == pals_pkg::OP_LOAD_INDEXED_CONSTANT
      |=> table_req && table_index == $past(stack[0][pals_pkg::WORD_W-1:0]))
      else $error("table offset not taken from first stack level");
   a_table_low_half: assert property ( // RL1
      state == pals_pkg::S_TBL && table_rvalid
      |=> acc_value == {pals_pkg::WORD_ZERO, $past(table_rdata)})
      else $error("table entry not placed in low accumulator half");
   a_real_const_exact: assert property ( // RL14
      state == pals_pkg::S_START && op == pals_pkg::OP_LOAD_REAL_CONST
      |=> acc_value == $past(operand) ##1 cmd_done)
      else $error("real constant not copied unchanged");
   a_word_store_low: assert property ( // RL7
      state == pals_pkg::S_ACCESS && op == pals_pkg::OP_STORE_WORD
      |=> mem_req && mem_we && mem_wdata == $past(acc_value[pals_pkg::WORD_W-1:0])
      ##1 !mem_req && cmd_done)
      else $error("word store wrote wrong data or extra cycles");
   a_double_store_pair: assert property ( // RL9
      state == pals_pkg::S_ACCESS && op == pals_pkg::OP_STORE_DOUBLE_WORD
      |=> mem_we && mem_addr == $past(eff_addr) ##1 mem_we
      && mem_addr == pals_pkg::next_addr($past(eff_addr, 2))
      && mem_wdata == $past(acc_value[pals_pkg::ACC_W-1:pals_pkg::WORD_W], 2))
      else $error("double store words not consecutive");
   a_fault_on_store: assert property ( // RL8
      fault_set |=> logic_fault_flag)
      else $error("fault flag missed during store");
   a_zero_after_load: assert property ( // RL12
      acc_wr |=> zero_result_flag == (acc_value == pals_pkg::ACC_RESET))
      else $error("zero flag disagrees with loaded value");
endmodule

// ### hw/pals_pkg.sv
// Function
// RL1 - indexed table load is 16-bit, label 1-FFFF
// RL2 - first stack level selects table entry
// RL3 - offset taken as plain binary
// RL4 - back-to-back loads push first load value
// RL5 - real load from two words or constant
// RL6 - real values occupy two adjacent words
// RL7 - word store writes accumulator low half
// RL8 - unsolvable logic during stores sets fault
// RL9 - double store writes two consecutive words
// RL10 - bit field store writes 1-32 bits
// RL11 - bit 0 to start, ascending addresses
// RL12 - zero load result sets zero flag
// RL13 - push shifts stack one level deeper
// RL14 - real load copies pattern unchanged
package pals_pkg;
   // ==========================================
   // widths and sizes
   localparam int WORD_W = 16;
   localparam int ACC_W = 32;
   localparam int CNT_W = 6;
   localparam int STACK_DEPTH = 8;
   // ==========================================
   // constants
   localparam logic [ACC_W-1:0] ACC_RESET = 32'h0000_0000;
   localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
   localparam logic [WORD_W-1:0] ADDR_STEP = 16'h0001;
   localparam logic [CNT_W-1:0] BITS_MIN = 6'h01;
   localparam logic [CNT_W-1:0] BITS_MAX = 6'h20;
   // ==========================================
   // instruction codes and sequencer states
   typedef enum logic [2:0] {
      OP_LOAD_INDEXED_CONSTANT,
      OP_LOAD_REAL_MEM,
      OP_LOAD_REAL_CONST,
      OP_STORE_WORD,
      OP_STORE_DOUBLE_WORD,
      OP_STORE_BIT_FIELD,
      OP_OTHER
   } pals_op_t;

   typedef enum logic [3:0] {
      S_IDLE, S_START, S_PTR, S_ACCESS, S_RD_LO, S_RD_HI,
      S_WR_HI, S_TBL, S_BITS, S_FINISH
   } pals_state_t;

   function automatic logic is_load(input pals_op_t op);
      return op == OP_LOAD_INDEXED_CONSTANT || op == OP_LOAD_REAL_MEM ||
             op == OP_LOAD_REAL_CONST;
   endfunction

   function automatic logic [WORD_W-1:0] next_addr(input logic [WORD_W-1:0] a);
      return WORD_W'(a + ADDR_STEP);
   endfunction
endpackage
